// >>> core/rx_buffer.sv
// Two byte receive buffer with separate high and low byte loads.
`include "rx_char_ctl_defs.svh"

module rx_buffer
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 load_high_byte,
  input  wire logic                 load_low_byte,
  input  wire logic [`WORD_W-1:0]   shift_data,
  output logic      [`WORD_W-1:0]   buffer_data
);
  import rx_char_ctl_pkg::*;

  logic [1:0]          lane_load;
  logic [`WORD_W-1:0]  next_buffer;

  assign lane_load = {load_high_byte, load_low_byte};

  // ----------------------------------------------------------------------
  // Byte lanes: lane 1 is the newest character, lane 0 the older one.
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : lane
      // Each lane keeps its old byte unless its own load is asserted.
      always_comb
      begin
        next_buffer[g*`CHAR_W +: `CHAR_W] = lane_load[g] ?
          shift_data[g*`CHAR_W +: `CHAR_W] :
          buffer_data[g*`CHAR_W +: `CHAR_W];
      end
    end
  endgenerate

  // Buffer flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer_data <= `ZERO_WORD;
    end
    else
    begin
      buffer_data <= next_buffer;
    end
  end

endmodule

// >>> core/rx_character_transfer_control.sv
// Receive character framing, sync stripping and DMA request control.
//
// The register offsets and register access over APB were decided locally.
`include "rx_char_ctl_defs.svh"

// Function
// [R1] Count characters in single or double framing, tracking odd/even count.
// [R2] Matched frame raises DMA request, loads buffer and rearms counting.
// [R3] Single framing with framing flag clear forces start stage set.
// [R4] Double framing starts both stages clear; two strobes make a request.
// [R5] Framing flag clear holds skip flag cleared.
// [R6] Load high byte always; load low byte only when skip flag clear.
// [R7] Skip flag sets at load pulse end, clears on next unblocked strobe.
// [R8] Transfer strobe follows load pulse and clocks both stages.
// [R9] Done stage fires frame reset pulse: sets request, clears done.
// [R10] Request clocks buffered data register onto bus data lines.
// [R11] Request still pending at frame reset sets late error, stops run.
// [R12] Bus side must service each request within one character time.
// [R13] Force bit with receive inactive requests transfer of shift data.
// [R14] Recognition mode, non-transparent, strip enabled: syncs block strobe.
// [R15] Transparent mode strips sync after escape using same blocking.
// [R16] Strip double char in recognition mode holds start stage clear.
// [R17] Stripped sync leaves skip set so sync never reaches memory.
// [R18] Inactive, run clear or bus init clear framing flags and counter.
// [R19] Request clears when bus completes the DMA transfer.
module rx_character_transfer_control
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`ADDR_W-1:0]  paddr,
  input  wire logic [`DATA_W-1:0]  pwdata,
  output logic      [`DATA_W-1:0]  prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                char_done,
  input  wire logic [`WORD_W-1:0]  shift_data,
  input  wire logic                framing_done_flag,
  input  wire logic                sync_char_detected,
  input  wire logic                escape_seen,
  input  wire logic                strip_double_char,
  input  wire logic                bus_init,
  input  wire logic                dma_done,
  output logic                     load_high_byte,
  output logic                     load_low_byte,
  output logic                     rx_transfer_strobe,
  output logic                     frame_reset_pulse,
  output logic                     rx_dma_request,
  output logic      [`WORD_W-1:0]  dma_data,
  output logic                     error_a,
  output logic                     receive_run,
  output logic                     framing_reset
);
  import rx_char_ctl_pkg::*;

  logic                 load_last;
  word_t                buffer_data;
  logic                 receive_active;
  logic                 strip_sync_enable;
  logic                 double_char_mode;
  logic                 char_recog_mode;
  logic                 transparent_mode;
  logic                 force_rx_transfer;
  logic                 frame_start_stage;
  logic                 frame_done_stage;
  logic                 skip_low_byte_load;
  logic                 strobe_block;
  logic                 force_pending;
  logic                 next_start;
  logic                 next_done;
  logic                 next_skip;
  logic                 next_block;
  logic                 next_reset_pulse;
  logic                 next_request;
  logic                 next_force_pending;
  word_t                next_dma_data;
  logic                 strobe_go;
  logic                 restart;
  logic                 wr_access;
  logic                 wr_csr;
  logic                 wr_err;
  logic                 wr_misc;
  logic                 late_set;
  logic                 force_fire;
  logic                 next_run;
  logic                 next_active;
  logic                 next_strip;
  logic                 next_double;
  logic                 next_recog;
  logic                 next_transp;
  logic                 next_force;
  logic                 next_error;
  logic                 next_framing_reset;
  logic [`DATA_W-1:0]   next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  rx_pulse_seq u_seq
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .char_done          (char_done),
    .skip_low_byte_load (skip_low_byte_load),
    .load_high_byte     (load_high_byte),      // [R6]
    .load_low_byte      (load_low_byte),       // [R6]
    .load_last          (load_last),
    .rx_transfer_strobe (rx_transfer_strobe)   // [R8]
  );

  rx_buffer u_buf
  (
    .pclk           (pclk),
    .presetn        (presetn),
    .load_high_byte (load_high_byte),
    .load_low_byte  (load_low_byte),
    .shift_data     (shift_data),
    .buffer_data    (buffer_data)
  );

  // ----------------------------------------------------------------------
  // Framing stages and skip flag
  // ----------------------------------------------------------------------
  // The block decision is caught when the character ends, because the
  // detector inputs move on with the next character shifting in.
  always_comb
  begin
    next_block = strobe_block;
    if (char_done)
    begin
      next_block = char_recog_mode & sync_char_detected &
                   ((~transparent_mode & strip_sync_enable) |   // [R14]
                    (transparent_mode & escape_seen));          // [R15]
    end
    strobe_go = rx_transfer_strobe & ~strobe_block;             // [R8]
    restart   = ~receive_active | ~receive_run | bus_init;      // [R18]
    next_start = frame_start_stage;
    next_done  = frame_done_stage;
    next_skip  = skip_low_byte_load;
    if (strobe_go)
    begin
      next_start = 1'b1;                                        // [R1]
      next_done  = frame_start_stage;                           // [R4]
      next_skip  = 1'b0;                                        // [R7]
    end
    if (load_last)
    begin
      next_skip = 1'b1;                                         // [R7] [R17]
    end
    if (frame_reset_pulse)
    begin
      next_done = 1'b0;                                         // [R9]
      if (double_char_mode)
      begin
        next_start = 1'b0;                                      // [R2] [R4]
      end
    end
    if (char_recog_mode & strip_double_char)
    begin
      next_start = 1'b0;                                        // [R16]
    end
    if (~framing_done_flag)
    begin
      next_skip = 1'b0;                                         // [R5]
      if (double_char_mode)
      begin
        next_start = 1'b0;                                      // [R4]
        next_done  = 1'b0;
      end
      else
      begin
        next_start = 1'b1;                                      // [R3]
      end
    end
    if (restart)
    begin
      next_start = ~double_char_mode;                           // [R18]
      next_done  = 1'b0;
      next_skip  = 1'b0;
    end
    next_reset_pulse = strobe_go & frame_start_stage &
                       ~frame_done_stage;                       // [R9]
  end

  // Stage flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_start_stage  <= 1'b0;
      frame_done_stage   <= 1'b0;
      skip_low_byte_load <= 1'b0;
      strobe_block       <= 1'b0;
      frame_reset_pulse  <= 1'b0;
    end
    else
    begin
      frame_start_stage  <= next_start;
      frame_done_stage   <= next_done;
      skip_low_byte_load <= next_skip;
      strobe_block       <= next_block;
      frame_reset_pulse  <= next_reset_pulse;
    end
  end

  // ----------------------------------------------------------------------
  // DMA request and buffered data register
  // ----------------------------------------------------------------------
  // Completion and a new request in one cycle keep the request set, so a
  // frame arriving just as the bus finishes is never dropped.
  always_comb
  begin
    force_fire = wr_misc & pwdata[`MISC_FORCE_BIT] &
                 ~receive_active;                               // [R13]
    late_set   = frame_reset_pulse & rx_dma_request;            // [R11]
    next_request       = rx_dma_request;
    next_force_pending = force_pending;
    next_dma_data      = dma_data;
    if (dma_done)
    begin
      next_request       = 1'b0;                                // [R19]
      next_force_pending = 1'b0;
    end
    if (frame_reset_pulse)
    begin
      next_request  = 1'b1;                                     // [R2] [R9]
      next_dma_data = buffer_data;                              // [R10]
    end
    else if (force_fire)
    begin
      next_request       = 1'b1;                                // [R13]
      next_force_pending = 1'b1;
      next_dma_data      = shift_data;                          // [R13]
    end
  end

  // Request flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_dma_request <= 1'b0;
      force_pending  <= 1'b0;
      dma_data       <= `ZERO_WORD;
    end
    else
    begin
      rx_dma_request <= next_request;
      force_pending  <= next_force_pending;
      dma_data       <= next_dma_data;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave and registers
  // ----------------------------------------------------------------------
  // The slave answers with pready in the first access cycle; read data
  // is captured in the setup cycle so prdata comes from a flop.
  always_comb
  begin
    wr_access = psel & penable & pready & pwrite;
    wr_csr    = wr_access & (paddr == `OFS_CSR);
    wr_err    = wr_access & (paddr == `OFS_ERR);
    wr_misc   = wr_access & (paddr == `OFS_MISC);
    next_run    = receive_run;
    next_active = receive_active;
    next_strip  = strip_sync_enable;
    next_double = double_char_mode;
    next_recog  = char_recog_mode;
    next_transp = transparent_mode;
    if (wr_csr)
    begin
      next_run    = pwdata[`CSR_RUN_BIT];
      next_active = pwdata[`CSR_ACTIVE_BIT];
      next_strip  = pwdata[`CSR_STRIP_BIT];
      next_double = pwdata[`CSR_DOUBLE_BIT];
      next_recog  = pwdata[`CSR_RECOG_BIT];
      next_transp = pwdata[`CSR_TRANSP_BIT];
    end
    next_error = error_a;
    if (wr_err & pwdata[`ERR_LATE_BIT])
    begin
      next_error = 1'b0;
    end
    if (late_set | bus_init)
    begin
      next_run = 1'b0;                                          // [R11]
    end
    if (late_set)
    begin
      next_error = 1'b1;                                        // [R11] [R12]
    end
    if (bus_init)
    begin
      next_active = 1'b0;
      next_error  = 1'b0;
    end
    next_force = force_pending & rx_dma_request;
    if (wr_misc)
    begin
      next_force = force_fire;
    end
    next_framing_reset = restart;                               // [R18]
    next_pready  = psel & ~penable;
    next_pslverr = 1'b0;
    next_prdata  = `ZERO_DATA;
    if (psel & ~penable & ~pwrite)
    begin
      case (paddr)
        `OFS_CSR:
        begin
          next_prdata[`CSR_RUN_BIT]    = receive_run;
          next_prdata[`CSR_ACTIVE_BIT] = receive_active;
          next_prdata[`CSR_STRIP_BIT]  = strip_sync_enable;
          next_prdata[`CSR_DOUBLE_BIT] = double_char_mode;
          next_prdata[`CSR_RECOG_BIT]  = char_recog_mode;
          next_prdata[`CSR_TRANSP_BIT] = transparent_mode;
        end
        `OFS_ERR:  next_prdata[`ERR_LATE_BIT] = error_a;
        `OFS_MISC: next_prdata[`MISC_FORCE_BIT] = force_rx_transfer;
        `OFS_DATA: next_prdata[`WORD_W-1:0] = dma_data;
        `OFS_STAT:
        begin
          next_prdata[`STAT_REQ_BIT]   = rx_dma_request;
          next_prdata[`STAT_START_BIT] = frame_start_stage;
          next_prdata[`STAT_DONE_BIT]  = frame_done_stage;
          next_prdata[`STAT_SKIP_BIT]  = skip_low_byte_load;
        end
        default:   next_pslverr = 1'b1;
      endcase
    end
    else if (psel & ~penable)
    begin
      case (paddr)
        `OFS_CSR, `OFS_ERR, `OFS_MISC, `OFS_DATA, `OFS_STAT:
          next_pslverr = 1'b0;
        default:
          next_pslverr = 1'b1;
      endcase
    end
  end

  // Register flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_run       <= 1'b0;
      receive_active    <= 1'b0;
      strip_sync_enable <= 1'b0;
      double_char_mode  <= 1'b0;
      char_recog_mode   <= 1'b0;
      transparent_mode  <= 1'b0;
      force_rx_transfer <= 1'b0;
      error_a           <= 1'b0;
      framing_reset     <= 1'b1;
      prdata            <= `ZERO_DATA;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
    end
    else
    begin
      receive_run       <= next_run;
      receive_active    <= next_active;
      strip_sync_enable <= next_strip;
      double_char_mode  <= next_double;
      char_recog_mode   <= next_recog;
      transparent_mode  <= next_transp;
      force_rx_transfer <= next_force;
      error_a           <= next_error;
      framing_reset     <= next_framing_reset;
      prdata            <= next_prdata;
      pready            <= next_pready;
      pslverr           <= next_pslverr;
    end
  end

endmodule

// >>> core/rx_pulse_seq.sv
// Buffer load pulse and transfer strobe sequencer.
`include "rx_char_ctl_defs.svh"

module rx_pulse_seq
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic char_done,
  input  wire logic skip_low_byte_load,
  output logic      load_high_byte,
  output logic      load_low_byte,
  output logic      load_last,
  output logic      rx_transfer_strobe
);
  import rx_char_ctl_pkg::*;

  seq_state_t              state;
  seq_state_t              next_state;
  logic [`SEQ_CNT_W-1:0]   cnt;
  logic [`SEQ_CNT_W-1:0]   next_cnt;
  logic                    next_low;

  // ----------------------------------------------------------------------
  // Sequence: load pulse, then transfer strobe as the load pulse ends.
  // ----------------------------------------------------------------------
  // A character ending while a sequence runs is ignored; the line rate
  // leaves many cycles between characters, so this cannot happen in use.
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_low   = load_low_byte;
    load_last  = 1'b0;
    case (state)
      SEQ_IDLE:
      begin
        if (char_done)
        begin
          next_state = SEQ_LOAD;
          next_cnt   = `ZERO_CNT;
          next_low   = ~skip_low_byte_load;
        end
      end
      SEQ_LOAD:
      begin
        if (cnt == `SEQ_CNT_W'(`LOAD_PULSE_CYC - 1))
        begin
          load_last  = 1'b1;
          next_state = SEQ_STROBE;
          next_cnt   = `ZERO_CNT;
          next_low   = 1'b0;
        end
        else
        begin
          next_cnt = cnt + `SEQ_CNT_W'(1);
        end
      end
      SEQ_STROBE:
      begin
        if (cnt == `SEQ_CNT_W'(`STROBE_PULSE_CYC - 1))
        begin
          next_state = SEQ_IDLE;
          next_cnt   = `ZERO_CNT;
        end
        else
        begin
          next_cnt = cnt + `SEQ_CNT_W'(1);
        end
      end
      default:
      begin
        next_state = SEQ_IDLE;
        next_cnt   = `ZERO_CNT;
        next_low   = 1'b0;
      end
    endcase
  end

  // Registered so the load and strobe outputs are glitch free.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state              <= SEQ_IDLE;
      cnt                <= `ZERO_CNT;
      load_high_byte     <= 1'b0;
      load_low_byte      <= 1'b0;
      rx_transfer_strobe <= 1'b0;
    end
    else
    begin
      state              <= next_state;
      cnt                <= next_cnt;
      load_high_byte     <= (next_state == SEQ_LOAD);
      load_low_byte      <= next_low;
      rx_transfer_strobe <= (next_state == SEQ_STROBE);
    end
  end

endmodule

// >>> shared/rx_char_ctl_defs.svh
// Constants for the receive character transfer control block.
`ifndef RX_CHAR_CTL_DEFS_SVH
`define RX_CHAR_CTL_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     100
`define LOAD_PULSE_NS     100
`define STROBE_PULSE_NS   50
`define LOAD_PULSE_CYC    ((`LOAD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_PULSE_CYC  ((`STROBE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEQ_CNT_W         3

// ----------------------------------------------------------------------
// Register offsets (byte addresses) and address width
// ----------------------------------------------------------------------
`define ADDR_W            8
`define OFS_CSR           8'h00
`define OFS_ERR           8'h04
`define OFS_MISC          8'h08
`define OFS_DATA          8'h0c
`define OFS_STAT          8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSR_RUN_BIT       0
`define CSR_STRIP_BIT     1
`define CSR_DOUBLE_BIT    2
`define CSR_RECOG_BIT     3
`define CSR_TRANSP_BIT    4
`define CSR_ACTIVE_BIT    12
`define ERR_LATE_BIT      3
`define MISC_FORCE_BIT    4
`define STAT_REQ_BIT      0
`define STAT_START_BIT    1
`define STAT_DONE_BIT     2
`define STAT_SKIP_BIT     3

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define DATA_W            32
`define CHAR_W            8
`define WORD_W            16
`define ZERO_WORD         16'h0000
`define ZERO_DATA         32'h0000_0000
`define ZERO_CNT          3'h0

`endif

// >>> shared/rx_char_ctl_pkg.sv
// Types shared by the receive character transfer control block.
package rx_char_ctl_pkg;

  // ----------------------------------------------------------------------
  // Pulse sequencer states, Gray coded along idle, load, strobe.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEQ_IDLE   = 2'b00,
    SEQ_LOAD   = 2'b01,
    SEQ_STROBE = 2'b11
  } seq_state_t;

  typedef logic [15:0] word_t;

endpackage

// >>> test/dma_model.sv
// Bus-side model that services receive DMA requests.
module dma_model
  import rx_char_ctl_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   rx_dma_request,
  input  wire rx_char_ctl_pkg::word_t dma_data,
  input  wire logic                   hold,
  output logic                        dma_done
);
  timeunit 1ns;
  timeprecision 1ns;
  word_t last_word;
  int    words;

  // Serve a request one cycle after it is seen; hold stalls the bus side.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_done <= 1'b0;
      words <= 0;
      last_word <= 16'h0000;
    end
    else
    begin
      dma_done <= rx_dma_request && !dma_done && !hold;
      if (rx_dma_request && !dma_done && !hold)
      begin
        last_word <= dma_data;
        words <= words + 1;
      end
    end
  end
endmodule

// >>> test/rx_ctl_monitor.sv
// Concurrent checks on the receive character transfer control ports.
module rx_ctl_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic char_done,
  input wire logic dma_done,
  input wire logic load_high_byte,
  input wire logic load_low_byte,
  input wire logic rx_transfer_strobe,
  input wire logic frame_reset_pulse,
  input wire logic rx_dma_request,
  input wire logic error_a,
  input wire logic receive_run,
  input wire logic framing_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A character taken while idle loads the buffer in the next cycle.
  a_load_char: assert property (
    char_done && !load_high_byte && !rx_transfer_strobe |=> load_high_byte)
    else $error("character not loaded");
  a_low_load: assert property (
    load_low_byte |-> load_high_byte) else $error("low byte load alone");
  a_strobe_next: assert property (
    load_high_byte |=> rx_transfer_strobe ##1 !rx_transfer_strobe)
    else $error("transfer strobe misplaced");
  a_reset_cause: assert property (
    frame_reset_pulse |-> $past(rx_transfer_strobe))
    else $error("frame reset without strobe");
  a_req_set: assert property (
    frame_reset_pulse |=> rx_dma_request) else $error("request not set");
  a_late_flag: assert property (
    frame_reset_pulse && rx_dma_request |=> error_a && !receive_run)
    else $error("overrun not flagged");
  a_req_clear: assert property (
    rx_dma_request && dma_done && !frame_reset_pulse && !psel
    |=> !rx_dma_request) else $error("request not cleared");
  a_run_reset: assert property (
    !receive_run |=> framing_reset) else $error("framing not reset");
  a_apb_ready: assert property (
    psel && !penable |=> pready) else $error("no ready");

  // The main paths that the bench must reach.
  c_frame: cover property (frame_reset_pulse);
  c_late: cover property (error_a);
  c_skip: cover property (load_high_byte && !load_low_byte);
endmodule

// >>> test/tb.sv
// Self-checking testbench for the receive character transfer control.
`include "rx_char_ctl_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, char_done = 1'b0, hold = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] shift_data = 16'h0000, dma_data;
  logic framing_done_flag = 1'b0, sync_char_detected = 1'b0, err, lo;
  logic escape_seen = 1'b0, strip_double_char = 1'b0, bus_init = 1'b0;
  logic dma_done, load_high_byte, load_low_byte, rx_transfer_strobe;
  logic frame_reset_pulse, rx_dma_request, error_a, receive_run;
  logic framing_reset;
  int failures = 0, comparisons = 0;

  rx_character_transfer_control rx_character_transfer_control_i (.*);
  dma_model dma_model_i (.*);

  always #50 pclk = ~pclk;

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a
  // rising edge, the answer is taken at that edge and only then released.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One character; leaves room for the request and its service.
  task automatic chr(input logic [15:0] d);
    @(posedge pclk);
    shift_data <= d;
    char_done <= 1'b1;
    @(posedge pclk);
    char_done <= 1'b0;
    @(negedge pclk);
    lo = load_low_byte;
    repeat (6) @(posedge pclk);
  endtask

  // Cuts a hang short long after the tests should have ended.
  initial
  begin
    repeat (3000) @(posedge pclk);
    failures++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CSR, 0);
    chk("csr", 0, rd);
    apb(1'b0, 8'h14, 0);
    chk("unmapped", 1, err);
    apb(1'b1, `OFS_CSR, 32'h1001);
    chr(16'h12ab);
    chk("single", 16'h12ab, dma_model_i.last_word);
    chk("frst_low", 0, framing_reset);
    $display("single done");
    framing_done_flag <= 1'b1;
    apb(1'b1, `OFS_CSR, 32'h0004);
    apb(1'b1, `OFS_CSR, 32'h1005);
    chr(16'h3400);
    chk("half", 1, dma_model_i.words);
    chr(16'h5634);
    chk("double", 16'h5634, dma_model_i.last_word);
    $display("double done");
    apb(1'b1, `OFS_CSR, 32'h000e);
    apb(1'b1, `OFS_CSR, 32'h100f);
    sync_char_detected <= 1'b1;
    chr(16'h9956);
    sync_char_detected <= 1'b0;
    chr(16'h1199);
    chk("skip", 0, lo);
    chr(16'h2211);
    chk("strip", 16'h2211, dma_model_i.last_word);
    chk("count", 3, dma_model_i.words);
    $display("strip done");
    apb(1'b1, `OFS_CSR, 32'h001a);
    apb(1'b1, `OFS_CSR, 32'h101b);
    sync_char_detected <= 1'b1;
    escape_seen <= 1'b1;
    chr(16'h7777);
    chk("transp", 3, dma_model_i.words);
    sync_char_detected <= 1'b0;
    escape_seen <= 1'b0;
    strip_double_char <= 1'b1;
    chr(16'h6666);
    chk("dbl", 3, dma_model_i.words);
    strip_double_char <= 1'b0;
    $display("transparent done");
    framing_done_flag <= 1'b0;
    hold <= 1'b1;
    apb(1'b1, `OFS_CSR, 32'h0000);
    apb(1'b1, `OFS_CSR, 32'h1001);
    chr(16'h0102);
    chr(16'h0304);
    chk("late", 1, error_a);
    chk("run", 0, receive_run);
    apb(1'b0, `OFS_ERR, 0);
    chk("err", 32'h8, rd);
    apb(1'b1, `OFS_ERR, 32'h8);
    apb(1'b0, `OFS_ERR, 0);
    chk("w1c", 0, rd);
    hold <= 1'b0;
    $display("overrun done");
    apb(1'b1, `OFS_CSR, 32'h0000);
    chk("frst", 1, framing_reset);
    shift_data <= 16'hbeef;
    apb(1'b1, `OFS_MISC, 32'h10);
    repeat (6) @(posedge pclk);
    chk("force", 16'hbeef, dma_model_i.last_word);
    chk("total", 5, dma_model_i.words);
    $display("force done");
    summarize();
  end
endmodule

bind rx_character_transfer_control rx_ctl_monitor rx_ctl_monitor_i (.*);
